// ---- design/rfrr_consts.vh ----
/*
 * constants for the rail fault record register bank: offsets, bit
 * positions and reset values.
 * assumes inclusion by bare name from the design file.
 */
`ifndef RFRR_CONSTS_VH
`define RFRR_CONSTS_VH

// ==========================================================
// register offsets
`define RFRR_RAIL2_RECORD_ADDR 8'h15
`define RFRR_RAIL3_RECORD_ADDR 8'h16

// ==========================================================
// field positions
`define RFRR_PG_BIT 7
`define RFRR_OV_BIT 5
`define RFRR_UV_BIT 4

// ==========================================================
// reset values
`define RFRR_RECORD_RESET 8'h00
`define RFRR_FLAG_RESET 1'b0

`endif

// ---- design/rfrr_regs.v ----
/*
 * fault record registers for rails 2 and 3: live power-good status,
 * sticky over- and under-voltage flags that clear on read.
 * assumes the register port gives a one-cycle read strobe with an
 * address, and that the analog front end delivers comparator levels
 * synchronous to clk.
 */
`timescale 1ns/1ps
`include "rfrr_consts.vh"

module rfrr_regs #(
  parameter ADDR_W = 8,
  parameter DATA_W = 8
) (
  input wire clk,
  input wire rst,
  input wire rail2_above_low,
  input wire rail2_below_high,
  input wire rail2_overvolt,
  input wire rail2_undervolt,
  input wire rail2_recovery,
  input wire rail3_above_low,
  input wire rail3_below_high,
  input wire rail3_overvolt,
  input wire rail3_undervolt,
  input wire rail3_recovery,
  input wire rd_en,
  input wire [ADDR_W-1:0] rd_addr,
  output reg [DATA_W-1:0] rd_data,
  output reg rd_valid,
  output wire rail2_power_good,
  output wire rail3_power_good,
  output wire rail2_overvolt_flag,
  output wire rail3_overvolt_flag,
  output wire rail2_undervolt_flag,
  output wire rail3_undervolt_flag
);

  // ==========================================================
  // rail bundles
  // index 0 carries rail 2 and index 1 carries rail 3
  localparam NUM_RAILS = 2;

  wire [NUM_RAILS-1:0] above_low;
  wire [NUM_RAILS-1:0] below_high;
  wire [NUM_RAILS-1:0] overvolt;
  wire [NUM_RAILS-1:0] undervolt;
  wire [NUM_RAILS-1:0] recovery;

  // lower window comparator
  assign above_low[0] = rail2_above_low;
  assign above_low[1] = rail3_above_low;

  // upper window comparator
  assign below_high[0] = rail2_below_high;
  assign below_high[1] = rail3_below_high;

  // over-voltage comparator
  assign overvolt[0] = rail2_overvolt;
  assign overvolt[1] = rail3_overvolt;

  // under-voltage comparator
  assign undervolt[0] = rail2_undervolt;
  assign undervolt[1] = rail3_undervolt;

  // fault recovery in progress
  assign recovery[0] = rail2_recovery;
  assign recovery[1] = rail3_recovery;

  // ==========================================================
  // record addresses
  // one address slot per rail, rail 2 in the low slot
  wire [NUM_RAILS*ADDR_W-1:0] rail_addrs;

  assign rail_addrs[ADDR_W-1:0] = `RFRR_RAIL2_RECORD_ADDR;
  assign rail_addrs[2*ADDR_W-1:ADDR_W] = `RFRR_RAIL3_RECORD_ADDR;

  // ==========================================================
  // read decode
  // one hit bit per rail, high only in the strobe cycle
  wire [NUM_RAILS-1:0] hit;

  // ==========================================================
  // per-rail state
  wire [NUM_RAILS-1:0] pg_vec;
  wire [NUM_RAILS-1:0] ov_vec;
  wire [NUM_RAILS-1:0] uv_vec;
  wire [NUM_RAILS*DATA_W-1:0] rec_flat;

  genvar g;
  generate
    for (g = 0; g < NUM_RAILS; g = g + 1) begin : g_rail
      reg pg_r;
      reg ov_r;
      reg ov_nxt;
      reg uv_r;
      reg uv_nxt;
      reg [DATA_W-1:0] rec;

      assign hit[g] = rd_en && (rd_addr == rail_addrs[g*ADDR_W +: ADDR_W]);

      // live power-good: strictly inside both limits
      // equality at a limit leaves its comparator low
      always @(posedge clk) begin
        if (rst) begin
          pg_r <= `RFRR_FLAG_RESET;
        end else begin
          pg_r <= above_low[g] & below_high[g];
        end
      end

      // a read clears after the data is captured; a new event wins
      always @* begin
        ov_nxt = (ov_r & ~hit[g]) | overvolt[g];
        uv_nxt = (uv_r & ~hit[g]) | undervolt[g]
          | recovery[g];
      end

      always @(posedge clk) begin
        if (rst) begin
          ov_r <= `RFRR_FLAG_RESET;
          uv_r <= `RFRR_FLAG_RESET;
        end else begin
          ov_r <= ov_nxt;
          uv_r <= uv_nxt;
        end
      end

      // record image; unused bits stay zero
      always @* begin
        rec = `RFRR_RECORD_RESET;
        rec[`RFRR_PG_BIT] = pg_r;
        rec[`RFRR_OV_BIT] = ov_r;
        rec[`RFRR_UV_BIT] = uv_r;
      end

      assign pg_vec[g] = pg_r;
      assign ov_vec[g] = ov_r;
      assign uv_vec[g] = uv_r;
      assign rec_flat[g*DATA_W +: DATA_W] = rec;
    end
  endgenerate

  // ==========================================================
  // status outputs
  // power-good lags its comparators by one cycle
  assign rail2_power_good = pg_vec[0];
  assign rail3_power_good = pg_vec[1];

  // sticky flags as held in the records
  assign rail2_overvolt_flag = ov_vec[0];
  assign rail3_overvolt_flag = ov_vec[1];
  assign rail2_undervolt_flag = uv_vec[0];
  assign rail3_undervolt_flag = uv_vec[1];

  // ==========================================================
  // read data mux
  // unmapped addresses read zero and clear nothing
  reg [DATA_W-1:0] rd_sel;
  integer k;

  always @* begin
    rd_sel = `RFRR_RECORD_RESET;
    for (k = 0; k < NUM_RAILS; k = k + 1) begin
      if (hit[k]) begin
        rd_sel = rec_flat[k*DATA_W +: DATA_W];
      end
    end
  end

  // ==========================================================
  // read port
  // data is taken from the record before the clear lands
  // and stands until the next strobe
  always @(posedge clk) begin
    if (rst) begin
      rd_data <= `RFRR_RECORD_RESET;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= rd_sel;
      end
    end
  end

endmodule

// ---- tb/rfrr_regs_props.sv ----
/* checker for rail 2 of rfrr_regs; sees only its ports */
`timescale 1ns/1ps
module rfrr_chk(input wire clk,rst,rd_en,rd_valid,rail2_overvolt,
  rail2_above_low,rail2_below_high,rail2_undervolt,rail2_recovery,
  rail2_power_good,rail2_overvolt_flag,rail2_undervolt_flag,
  input wire [7:0] rd_addr,rd_data);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire w=rail2_above_low&rail2_below_high,r=rd_en&&rd_addr==8'h15;
wire u=rail2_undervolt|rail2_recovery,p=rail2_power_good;
wire o=rail2_overvolt,fo=rail2_overvolt_flag,fu=rail2_undervolt_flag;
a_pg_in: assert property (w|=>p) else $error("pg low");
a_pg_out: assert property (!w|=>!p) else $error("pg high");
a_ov_set: assert property (o|=>fo) else $error("ov lost");
a_ov_clr: assert property (r&&!o|=>!fo) else $error("ov kept");
a_uv_set: assert property (u|=>fu) else $error("uv lost");
a_uv_clr: assert property (r&&!u|=>!fu) else $error("uv kept");
a_rd_old: assert property (r|=>rd_valid&&rd_data[5]==$past(fo))
  else $error("rd data");
endmodule
bind rfrr_regs rfrr_chk u_chk(.*);

// ---- tb/rfrr_host.sv ----
/* host read model; assumes a one-cycle answer */
`timescale 1ns/1ps
module rfrr_host(input wire clk,rd_valid,input wire [7:0] rd_data,
  output reg rd_en=0,output reg [7:0] rd_addr=0);
task rd(input [7:0] a,output [7:0] d);
  @(posedge clk) rd_en<=1;
  rd_addr<=a;
  @(posedge clk) rd_en<=0;
  rd_addr<=~a;
  @(posedge clk) d=rd_valid?rd_data:8'hee;
endtask
endmodule

// ---- tb/rfrr_regs_tb.sv ----
/* bench for rfrr_regs; reads go through rfrr_host */
`timescale 1ns/1ps
module rfrr_regs_tb;
reg clk=0,rst=1;
reg [4:0] v=0;
reg [7:0] d,e;
integer mismatches=0,num_checks=0,i,j;
reg [20:0] t[5]='{21'h188080,21'h142010,21'h0a1020,21'h199090,21'h1eb0b0};
wire rd_en,rd_valid,rail2_power_good,rail3_power_good,rail2_overvolt_flag,
  rail3_overvolt_flag,rail2_undervolt_flag,rail3_undervolt_flag;
wire [7:0] rd_addr,rd_data;
wire [7:0] flags={2'b0,rail2_power_good,rail2_overvolt_flag,
  rail2_undervolt_flag,rail3_power_good,rail3_overvolt_flag,
  rail3_undervolt_flag};
wire rail2_above_low=v[4],rail2_below_high=v[3],rail2_overvolt=v[2],
  rail2_undervolt=v[1],rail2_recovery=v[0],rail3_above_low=v[4],
  rail3_below_high=v[3],rail3_overvolt=v[1],rail3_undervolt=v[2],
  rail3_recovery=v[0];
rfrr_regs dut(.*);
rfrr_host host(.*);
initial forever #50 clk=~clk;
task chk(input [7:0] e,g);
  num_checks++;
  if (g!==e) begin mismatches++; $display("BAD %0t %h %h",$time,e,g); end
endtask
task report_and_stop;
  $display("%0d checks %0d bad",num_checks,mismatches);
  if (mismatches==0&&num_checks>0) $display("TEST PASSED");
  else $display("TEST FAILED");
  $finish;
endtask
initial #400000 begin mismatches++; report_and_stop; end
initial begin
  repeat(8) @(posedge clk);
  rst<=0;
  for (i=0;i<5;i++) begin
    @(posedge clk) v<=t[i][20:16];
    @(posedge clk) v[2:0]<=0;
    e={2'b0,t[i][15],t[i][13:12],t[i][7],t[i][5:4]};
    #1 chk(e,flags);
    for (j=0;j<4;j++) begin
      host.rd(8'h15+j[1],d);
      chk(t[i][15-8*j[1]-:8]&(j[0]?8'h80:8'hff),d);
    end
    $display("row %0d ok",i);
  end
  @(posedge clk) v<=5'h1c;
  host.rd(8'h17,d);
  chk(0,d);
  host.rd(8'h15,d);
  chk(8'ha0,d);
  host.rd(8'h15,d);
  chk(8'ha0,d);
  host.rd(8'h16,d);
  chk(8'h90,d);
  $display("held events ok");
  @(posedge clk) rst<=1;
  @(posedge clk) v<=0;
  @(posedge clk) rst<=0;
  #1 chk(0,flags);
  host.rd(8'h16,d);
  chk(0,d);
  $display("reset test ok");
  report_and_stop;
end
endmodule
